// [verification/sslt_sensor_model.sv]
// sslt_sensor_model: behavioural linear sensor, counts the clock edges the timing block sends it
// assumes: its inputs are registered outputs of the timing block, sampled on mclk
`timescale 1ns/100ps
module sslt_sensor_model (
  input  wire logic mclk,
  input  wire logic phi1,
  input  wire logic tr_red,
  input  wire logic tr_green,
  input  wire logic tr_blue,
  output int        phi_rises,
  output int        red_rises,
  output int        green_rises,
  output int        blue_rises
);
  logic p_q = 1'b0, r_q = 1'b0, g_q = 1'b0, b_q = 1'b0;
  // a real sensor only reacts to edges, so only rising edges are counted; counters start at 0 as 2-state ints
  always @(posedge mclk) begin
    if (phi1 && !p_q) phi_rises <= phi_rises + 1;
    if (tr_red && !r_q) red_rises <= red_rises + 1;
    if (tr_green && !g_q) green_rises <= green_rises + 1;
    if (tr_blue && !b_q) blue_rises <= blue_rises + 1;
    {p_q, r_q, g_q, b_q} <= {phi1, tr_red, tr_green, tr_blue};
  end
endmodule

// [verification/test_sslt_timing.sv]
// test_sslt_timing: self-checking bench for the lamp and sensor timing block
// assumes: sslt_pkg compiled first; inputs driven on the falling edge of mclk
`timescale 1ns/100ps
module test_sslt_timing import sslt_pkg::*;;
  typedef struct packed {sslt_illum_t il; sslt_afe_t afe; sslt_colour_t sel; logic inv; logic [2:0] lamps;} sslt_row_t;
  logic mclk, srst, chip_reset, standby, osc, scan_req, inv, dual, fake, lamp_r, lamp_g, lamp_b, phi1, phi2;
  logic tr_a, tr_b, rs, cp1, cp2, clamp, strobe, st_inv, int_ref, line_start, scan_start;
  logic [15:0] line_end, black_end, on_r, off_r, on_g, off_g, on_b, off_b, tr_width, tr_guard;
  logic [11:0] duty;
  logic [5:0]  skip_cfg;
  logic [2:0]  pos2_cfg;
  logic [2:0]  rs_rise;
  logic        rs_q;
  sslt_illum_t  illum;
  sslt_afe_t    afe;
  sslt_trmode_t trm;
  sslt_colour_t sel, adc_chan, coef_chan, colour, prev;
  int err_total = 0, num_checks = 0, pr, rr, gr, br, c0, c1, c2, c3, wa, wb, bad;
  sslt_row_t rows [4] = '{
    '{SSLT_ILLUM_OFF, SSLT_AFE_ONE, SSLT_BLUE, 1'b0, 3'b000},
    '{SSLT_ILLUM_WHITE, SSLT_AFE_ONE, SSLT_GREEN, 1'b1, 3'b100},
    '{SSLT_ILLUM_GREY, SSLT_AFE_ONE, SSLT_RED, 1'b0, 3'b111},
    '{SSLT_ILLUM_GREY, SSLT_AFE_LINE, SSLT_RED, 1'b1, 3'b111}};
  sslt_timing i_sslt_timing (.mclk(mclk), .srst(srst), .chip_reset(chip_reset), .standby(standby),
    .oscillator_input(osc), .illum_mode(illum), .line_end(line_end), .black_end(black_end),
    .lamp_on_r(on_r), .lamp_off_r(off_r), .lamp_on_g(on_g), .lamp_off_g(off_g), .lamp_on_b(on_b),
    .lamp_off_b(off_b), .pwm_duty(duty), .scan_req(scan_req), .input_invert(inv), .dual_sampling(dual),
    .tr_width(tr_width), .tr_guard(tr_guard), .tr_mode(trm), .fake_black(fake), .rs_rise(rs_rise),
    .rs_fall(3'h3), .cp1_rise(3'h2), .cp1_fall(3'h5), .cp2_rise(3'h4), .cp2_fall(3'h6), .afe_mode(afe),
    .one_chan_sel(sel), .skip_cfg(skip_cfg), .pos2_cfg(pos2_cfg), .lamp_r(lamp_r), .lamp_g(lamp_g),
    .lamp_b(lamp_b), .phi1(phi1), .phi2(phi2), .transfer_pulse_a(tr_a), .transfer_pulse_b(tr_b),
    .reset_sample_pulse(rs), .aux_pixel_pulse_a(cp1), .aux_pixel_pulse_b(cp2), .clamp(clamp),
    .adc_strobe(strobe), .adc_chan(adc_chan), .coef_chan(coef_chan), .stage_invert(st_inv),
    .sample_int_ref(int_ref), .line_start(line_start), .scan_start(scan_start), .line_colour(colour));
  sslt_sensor_model i_sslt_sensor_model (.mclk(mclk), .phi1(phi1), .tr_red(tr_a), .tr_green(tr_b),
    .tr_blue(cp2), .phi_rises(pr), .red_rises(rr), .green_rises(gr), .blue_rises(br));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic cmp(string name, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cmp_int(string name, int exp, int got);
    num_checks++;
    if (got != exp) begin
      err_total++;
      $display("[ERR] %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  task automatic wait_ls;
    int n;
    n = 0;
    do begin @(negedge mclk); n++; end while (line_start !== 1'b1 && n < 300);
    if (n >= 300) cmp("line_start", 16'h0001, 16'h0000);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    err_total++;
    $display("[ERR] watchdog expired");
    test_done;
  end
  initial begin
    {srst, chip_reset, standby, osc, scan_req, inv, dual, fake} = 8'h80;
    {line_end, black_end, tr_width, tr_guard} = {16'h0007, 16'h0002, 16'h0005, 16'h0002};
    {on_r, off_r, on_g, off_g, on_b, off_b} = {16'h0001, 16'h0009, 16'h0001, 16'h0009, 16'h0009, 16'h0001};
    illum = SSLT_ILLUM_OFF;
    afe = SSLT_AFE_PIXEL;
    trm = SSLT_TR_NORMAL;
    sel = SSLT_RED;
    {duty, skip_cfg, pos2_cfg, rs_rise} = {12'h000, 6'h00, 3'h0, 3'h1};
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    cmp("lamps after reset", 16'h0000, {lamp_r, lamp_g, lamp_b});
    srst = 1'b0;
    foreach (rows[i]) begin
      illum = rows[i].il;
      afe = rows[i].afe;
      sel = rows[i].sel;
      inv = rows[i].inv;
      dual = ~rows[i].inv;
      wait_ls;
      wait_ls;
      repeat (20) @(negedge mclk);
      cmp("lamps", rows[i].lamps, {lamp_r, lamp_g, lamp_b});
      cmp("polarity and ref", {2{rows[i].inv}}, {st_inv, int_ref});
      if (rows[i].afe == SSLT_AFE_ONE) cmp("chan", {sel, sel}, {adc_chan, coef_chan});
      $display("row %0d done", i);
    end
    afe = SSLT_AFE_PIXEL;
    repeat (3) begin
      do @(negedge mclk); while (strobe !== 1'b1);
      prev = adc_chan;
      repeat (8) @(negedge mclk);
      cmp("strobe period", 16'h0001, strobe);
      cmp("chan rotate", (prev == SSLT_BLUE) ? SSLT_RED : prev + 2'h1, adc_chan);
    end
    {on_b, off_b} = {16'h0001, 16'h0009};
    illum = SSLT_ILLUM_COLOR;
    afe = SSLT_AFE_LINE;
    wait_ls;
    prev = colour;
    repeat (4) begin
      wait_ls;
      cmp("colour step", (prev == SSLT_BLUE) ? SSLT_RED : prev + 2'h1, colour);
      prev = colour;
      repeat (20) @(negedge mclk);
      cmp("colour lamp", {colour == SSLT_RED, colour == SSLT_GREEN, colour == SSLT_BLUE}, {lamp_r, lamp_g, lamp_b});
      cmp("line chan", colour, adc_chan);
    end
    scan_req = 1'b1;
    @(negedge mclk);
    scan_req = 1'b0;
    do wait_ls; while (scan_start !== 1'b1 && line_start === 1'b1 && colour !== SSLT_RED);
    cmp("scan start red line", {1'b1, SSLT_RED}, {scan_start, colour});
    $display("colour and scan test done");
    illum = SSLT_ILLUM_OFF;
    afe = SSLT_AFE_PIXEL;
    for (int k = 0; k < 4; k++) begin
      trm = (k < 2) ? SSLT_TR_NORMAL : sslt_trmode_t'(k - 1);
      tr_guard = (k == 1) ? 16'h0000 : 16'h0002;
      wait_ls;
      {wa, wb, bad} = 0;
      repeat (64) begin
        @(negedge mclk);
        wa += tr_a;
        wb += tr_b;
        bad += (tr_a != phi1 && phi1 == 1'b0);
      end
      cmp_int("tr_a width", (k < 2) ? 5 : 8, wa);
      if (k < 2) cmp_int("tr_b width", 5, wb);
      if (k == 1) cmp_int("tr without phi1", 0, bad);
    end
    trm = SSLT_TR_NORMAL;
    afe = SSLT_AFE_LINE;
    {tr_guard, skip_cfg, pos2_cfg} = {16'h0002, 6'h21, 3'h5};
    wait_ls;
    wait_ls;
    {c0, c1, c2} = {rr, gr, br};
    repeat (6) wait_ls;
    cmp_int("red pulses", 3, rr - c0);
    cmp_int("green pulses", 6, gr - c1);
    cmp_int("blue pulses", 2, br - c2);
    // one line of pixel pulses, clamp and fake black; the next line start is left out of the count
    afe = SSLT_AFE_PIXEL;
    for (int k = 0; k < 3; k++) begin
      rs_rise = (k == 1) ? 3'h0 : 3'h1;
      fake = (k == 2);
      black_end = (k == 2) ? 16'h0004 : 16'h0002;
      wait_ls;
      {wa, wb, bad, c0, c1, c2} = 0;
      rs_q = rs;
      repeat (63) begin
        @(negedge mclk);
        wa += rs;
        wb += cp1;
        bad += clamp;
        c0 += tr_a;
        c1 += (rs && tr_a);
        c2 += (rs && !rs_q);
        rs_q = rs;
      end
      cmp_int("clamp width", black_end * 8, bad);
      cmp_int("cp1 width", 21, wb);
      if (k < 2) cmp_int("rs width", k ? 21 : 14, wa);
      else begin
        cmp_int("fake tr width", 13, c0);
        cmp_int("fake rs rises", 2, c2);
        cmp_int("fake rs in tr", 1, c1);
      end
      $display("pulse row %0d done", k);
    end
    {fake, black_end} = {1'b0, 16'h0002};
    illum = SSLT_ILLUM_GREY;
    for (int k = 0; k < 2; k++) begin
      {chip_reset, standby} = k ? 2'b10 : 2'b01;
      repeat (3) @(negedge mclk);
      c3 = pr;
      repeat (16) begin
        @(negedge mclk);
        cmp("stopped", 16'h0000, {phi1, phi2, strobe, lamp_r});
      end
      cmp_int("phi rises stopped", c3, pr);
      {chip_reset, standby} = 2'b00;
      repeat (2) @(negedge mclk);
      cmp("colour after wake", SSLT_RED, colour);
      repeat (24) @(negedge mclk);
      cmp("clocks resumed", 16'h0001, pr > c3);
    end
    illum = SSLT_ILLUM_WHITE;
    for (int k = 0; k < 2; k++) begin
      duty = k ? 12'h001 : 12'h800;
      repeat (8) @(negedge mclk);
      c3 = 0;
      repeat (4096) begin
        osc = 1'b1;
        repeat (2) @(negedge mclk);
        osc = 1'b0;
        repeat (2) @(negedge mclk);
        c3 += lamp_g;
      end
      cmp_int("pwm high count", k ? 1 : 2048, c3);
    end
    $display("pwm test done");
    test_done;
  end
endmodule

// [verilog/sslt_cfg.svh]
// sslt_cfg.svh: fixed offsets, counts and reset values of the scanner lamp and sensor timing block
// assumes: included by bare name, once, before the module that uses it
`ifndef SSLT_CFG_SVH
`define SSLT_CFG_SVH
`define SSLT_PHASE_ZERO    3'h0
`define SSLT_PHASE_STEP    3'h1
`define SSLT_PHASE_LAST    3'h7
`define SSLT_PHI1_FALL     3'h4
`define SSLT_CNT_ZERO      16'h0000
`define SSLT_CNT_STEP      16'h0001
`define SSLT_CNT_MAX       16'hffff
`define SSLT_TR_M1_START   16'h0000
`define SSLT_TR_M2_START   16'h0006
`define SSLT_PHI_PERIOD    16'h0008
`define SSLT_POS2_OFFSET   16'h0004
`define SSLT_FAKE_EXT      16'h0008
`define SSLT_FAKE_PULSE_AT 16'h0002
`define SSLT_PWM_ZERO      12'h000
`define SSLT_PWM_STEP      12'h001
`define SSLT_SKIP_ZERO     2'h0
`define SSLT_SKIP_STEP     2'h1
`endif

// [verilog/sslt_pkg.sv]
// sslt_pkg: types shared by the scanner lamp and sensor timing block
// assumes: compiled before the timing module
package sslt_pkg;
  typedef enum logic [1:0] {
    SSLT_ILLUM_OFF   = 2'b00,
    SSLT_ILLUM_WHITE = 2'b01,
    SSLT_ILLUM_COLOR = 2'b10,
    SSLT_ILLUM_GREY  = 2'b11
  } sslt_illum_t;
  typedef enum logic [1:0] {
    SSLT_AFE_PIXEL = 2'b00,
    SSLT_AFE_LINE  = 2'b01,
    SSLT_AFE_ONE   = 2'b10
  } sslt_afe_t;
  typedef enum logic [1:0] {
    SSLT_TR_NORMAL = 2'b00,
    SSLT_TR_CIS1   = 2'b01,
    SSLT_TR_CIS2   = 2'b10
  } sslt_trmode_t;
  typedef enum logic [1:0] {
    SSLT_RED   = 2'b00,
    SSLT_GREEN = 2'b01,
    SSLT_BLUE  = 2'b10
  } sslt_colour_t;
endpackage

// [verilog/sslt_timing.sv]
// sslt_timing: lamp drive, sensor clocks and converter channel sequencing of a scanner front end
// assumes: all inputs synchronous to mclk; oscillator_input is a slow level sampled on mclk
`timescale 1ns/100ps
`include "sslt_cfg.svh"
module sslt_timing import sslt_pkg::*; (
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire logic         chip_reset,
  input  wire logic         standby,
  input  wire logic         oscillator_input,
  input  wire sslt_illum_t  illum_mode,
  input  wire logic [15:0]  line_end,
  input  wire logic [15:0]  black_end,
  input  wire logic [15:0]  lamp_on_r,
  input  wire logic [15:0]  lamp_off_r,
  input  wire logic [15:0]  lamp_on_g,
  input  wire logic [15:0]  lamp_off_g,
  input  wire logic [15:0]  lamp_on_b,
  input  wire logic [15:0]  lamp_off_b,
  input  wire logic [11:0]  pwm_duty,
  input  wire logic         scan_req,
  input  wire logic         input_invert,
  input  wire logic         dual_sampling,
  input  wire logic [15:0]  tr_width,
  input  wire logic [15:0]  tr_guard,
  input  wire sslt_trmode_t tr_mode,
  input  wire logic         fake_black,
  input  wire logic [2:0]   rs_rise,
  input  wire logic [2:0]   rs_fall,
  input  wire logic [2:0]   cp1_rise,
  input  wire logic [2:0]   cp1_fall,
  input  wire logic [2:0]   cp2_rise,
  input  wire logic [2:0]   cp2_fall,
  input  wire sslt_afe_t    afe_mode,
  input  wire sslt_colour_t one_chan_sel,
  input  wire logic [5:0]   skip_cfg,
  input  wire logic [2:0]   pos2_cfg,
  output logic              lamp_r,
  output logic              lamp_g,
  output logic              lamp_b,
  output logic              phi1,
  output logic              phi2,
  output logic              transfer_pulse_a,
  output logic              transfer_pulse_b,
  output logic              reset_sample_pulse,
  output logic              aux_pixel_pulse_a,
  output logic              aux_pixel_pulse_b,
  output logic              clamp,
  output logic              adc_strobe,
  output sslt_colour_t      adc_chan,
  output sslt_colour_t      coef_chan,
  output logic              stage_invert,
  output logic              sample_int_ref,
  output logic              line_start,
  output logic              scan_start,
  output sslt_colour_t      line_colour
);

  function automatic logic in_win(input logic [15:0] cnt, input logic [15:0] start, input logic [15:0] len);
    logic [16:0] stop;
    stop = {1'h0, start} + {1'h0, len};
    in_win = ({1'h0, cnt} >= {1'h0, start}) && ({1'h0, cnt} < stop);
  endfunction

  function automatic logic in_phase(input logic [2:0] ph, input logic [2:0] rise, input logic [2:0] fall);
    in_phase = (ph >= rise) && (ph < fall);
  endfunction

  function automatic sslt_colour_t colour_after(input sslt_colour_t c);
    unique case (c)
      SSLT_RED:   colour_after = SSLT_GREEN;
      SSLT_GREEN: colour_after = SSLT_BLUE;
      SSLT_BLUE:  colour_after = SSLT_RED;
      default:    colour_after = SSLT_RED;
    endcase
  endfunction

  logic         [2:0]  phase;
  logic         [15:0] pix;
  logic         [15:0] tr_cnt;
  sslt_colour_t        col;
  sslt_colour_t        pr_chan;
  logic         [11:0] pwm_cnt;
  logic                osc_q;
  logic                pending;
  logic                fake_hold;
  logic         [2:0]  lamp_st;
  logic         [5:0]  skip_left;

  // reset and standby stop all sensor clocking and every counter
  wire run = !srst && !chip_reset && !standby;
  wire pix_end = (pix == line_end);
  wire wrap = run && (phase == `SSLT_PHASE_LAST) && pix_end;
  wire black_hit = (pix == black_end);
  wire sslt_colour_t next_col = wrap ? colour_after(col) : col;
  wire [2:0] next_phase = run ? phase + `SSLT_PHASE_STEP : `SSLT_PHASE_ZERO;
  wire [15:0] next_pix = (!run || wrap) ? `SSLT_CNT_ZERO
                       : (phase == `SSLT_PHASE_LAST) ? pix + `SSLT_CNT_STEP : pix;
  wire [15:0] next_tr_cnt = (!run || wrap) ? `SSLT_CNT_ZERO
                          : (tr_cnt == `SSLT_CNT_MAX) ? tr_cnt : tr_cnt + `SSLT_CNT_STEP;

  // scan waits for a line boundary; colour mode also waits for red
  wire start_ok = wrap && (illum_mode != SSLT_ILLUM_COLOR || next_col == SSLT_RED);
  wire next_scan_start = start_ok && (pending || scan_req);
  wire next_pending = run && (pending || scan_req) && !next_scan_start;

  always_ff @(posedge mclk) begin
    phase   <= next_phase;
    pix     <= next_pix;
    tr_cnt  <= next_tr_cnt;
    col     <= run ? next_col : SSLT_RED;
    pending <= next_pending;
  end

  // pwm runs from oscillator edges, so its period tracks the crystal, not mclk
  wire osc_rise = oscillator_input && !osc_q;
  wire [11:0] next_pwm = !run ? `SSLT_PWM_ZERO : osc_rise ? pwm_cnt + `SSLT_PWM_STEP : pwm_cnt;
  wire green_pwm = (pwm_cnt < pwm_duty);

  always_ff @(posedge mclk) begin
    osc_q   <= srst ? 1'h0 : oscillator_input;
    pwm_cnt <= srst ? `SSLT_PWM_ZERO : next_pwm;
  end

  // pointer compare; off wins on a tie; a pointer past line end never matches
  wire [2:0] hit_on  = {pix == lamp_on_b, pix == lamp_on_g, pix == lamp_on_r};
  wire [2:0] hit_off = {pix == lamp_off_b, pix == lamp_off_g, pix == lamp_off_r};
  wire [2:0] next_lamp_st = !run ? 3'h0 : (lamp_st | hit_on) & ~hit_off;
  wire [2:0] col_onehot = {col == SSLT_BLUE, col == SSLT_GREEN, col == SSLT_RED};
  wire [2:0] lamp_mode2 = lamp_st & col_onehot;
  logic [2:0] next_lamps;

  always_comb begin
    unique case (illum_mode)
      SSLT_ILLUM_OFF:   next_lamps = 3'h0;
      SSLT_ILLUM_WHITE: next_lamps = {lamp_st[2], green_pwm, lamp_st[0]};
      SSLT_ILLUM_COLOR: next_lamps = lamp_mode2;
      SSLT_ILLUM_GREY:  next_lamps = 3'h7;
    endcase
    if (!run) begin
      next_lamps = 3'h0;
    end
  end

  always_ff @(posedge mclk) begin
    lamp_st <= next_lamp_st;
    {lamp_b, lamp_g, lamp_r} <= srst ? 3'h0 : next_lamps;
  end

  // transfer timing: one shared width for both outputs
  wire [15:0] w_eff = fake_black ? tr_width + `SSLT_FAKE_EXT : tr_width;
  wire [15:0] hold_len = tr_guard + tr_guard + w_eff;
  wire tr_norm_win = in_win(tr_cnt, tr_guard, w_eff);
  wire phi_hold = (tr_mode == SSLT_TR_NORMAL) && in_win(tr_cnt, `SSLT_CNT_ZERO, hold_len);
  wire tr_cis1 = in_win(tr_cnt, `SSLT_TR_M1_START, `SSLT_PHI_PERIOD);
  wire tr_cis2 = in_win(tr_cnt, `SSLT_TR_M2_START, `SSLT_PHI_PERIOD);
  wire tr_main = (tr_mode == SSLT_TR_CIS1) ? tr_cis1
               : (tr_mode == SSLT_TR_CIS2) ? tr_cis2 : tr_norm_win;
  wire next_phi1 = run && ((phase < `SSLT_PHI1_FALL) || phi_hold);
  wire next_phi2 = run && !next_phi1;

  // line-rate transfers: per colour window, position and skip count
  wire line_rate = (afe_mode == SSLT_AFE_LINE);
  logic [2:0] lr_win;
  logic [2:0] lr_fire;
  logic [5:0] next_skip;
  genvar c;
  for (c = 0; c < 3; c++) begin : g_colour
    wire [15:0] lr_start = pos2_cfg[c] ? `SSLT_POS2_OFFSET : `SSLT_CNT_ZERO;
    assign lr_win[c] = in_win(tr_cnt, lr_start, tr_width);
    assign lr_fire[c] = (skip_left[2*c +: 2] == `SSLT_SKIP_ZERO);
    assign next_skip[2*c +: 2] = !run ? `SSLT_SKIP_ZERO
                               : !wrap ? skip_left[2*c +: 2]
                               : lr_fire[c] ? skip_cfg[2*c +: 2]
                               : skip_left[2*c +: 2] - `SSLT_SKIP_STEP;
  end
  wire [2:0] lr_tr = lr_win & lr_fire;

  // pixel-rate pulses, forced off through the line-end pixel
  wire rs_pix  = in_phase(phase, rs_rise, rs_fall) && !pix_end;
  wire cp1_pix = in_phase(phase, cp1_rise, cp1_fall) && !pix_end;
  wire cp2_pix = in_phase(phase, cp2_rise, cp2_fall) && !pix_end;
  wire fake_end_w = (tr_cnt == tr_guard + w_eff);
  wire next_fake_hold = run && fake_black && !black_hit && (fake_hold || fake_end_w);
  wire rs_fake = (tr_cnt == tr_guard + `SSLT_FAKE_PULSE_AT) || fake_hold;
  wire next_rs = run && (fake_black ? rs_fake : rs_pix);
  wire next_tr_a = run && (line_rate ? lr_tr[0] : tr_main);
  wire next_tr_b = run && (line_rate ? lr_tr[1] : tr_main);
  wire next_cp2 = run && (line_rate ? lr_tr[2] : cp2_pix);
  // clamp spans the optical black pixels of every line except the first one after run starts
  wire next_clamp = run && !black_hit && (wrap || clamp);

  always_ff @(posedge mclk) begin
    skip_left          <= next_skip;
    fake_hold          <= next_fake_hold;
    phi1               <= next_phi1;
    phi2               <= next_phi2;
    transfer_pulse_a   <= next_tr_a;
    transfer_pulse_b   <= next_tr_b;
    reset_sample_pulse <= next_rs;
    aux_pixel_pulse_a  <= run && cp1_pix;
    aux_pixel_pulse_b  <= next_cp2;
    clamp              <= next_clamp;
  end

  // converter: one conversion per pixel period, i.e. mclk/8
  wire conv = run && (phase == `SSLT_PHASE_LAST);
  wire sslt_colour_t next_pr = !run ? SSLT_RED : conv ? colour_after(pr_chan) : pr_chan;
  sslt_colour_t next_adc_chan;

  always_comb begin
    unique case (afe_mode)
      SSLT_AFE_PIXEL: next_adc_chan = pr_chan;
      SSLT_AFE_LINE:  next_adc_chan = col;
      default:        next_adc_chan = one_chan_sel;
    endcase
  end

  // variant A only: coefficients always follow the converted channel
  always_ff @(posedge mclk) begin
    pr_chan        <= next_pr;
    adc_strobe     <= conv;
    adc_chan       <= srst ? SSLT_RED : next_adc_chan;
    coef_chan      <= srst ? SSLT_RED : next_adc_chan;
    stage_invert   <= !srst && input_invert;
    sample_int_ref <= !srst && !dual_sampling;
    line_start     <= wrap;
    scan_start     <= next_scan_start;
    line_colour    <= srst ? SSLT_RED : next_col;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_mode0_lamps_dark:
    assert property (illum_mode == SSLT_ILLUM_OFF |=> !lamp_r && !lamp_g && !lamp_b)
    else $error("lamp lit in mode 0");
  a_green_pwm_follow:
    assert property (run && illum_mode == SSLT_ILLUM_WHITE |=> lamp_g == $past(green_pwm))
    else $error("green lamp does not follow pwm compare");
  a_grey_all_on:
    assert property (run && illum_mode == SSLT_ILLUM_GREY |=> lamp_r && lamp_g && lamp_b)
    else $error("grey mode lamp off");
  a_stop_sensor_clocks:
    assert property (!run |=> !phi1 && !transfer_pulse_a && !reset_sample_pulse && !adc_strobe)
    else $error("sensor clocked while stopped");
  a_transfer_same_width:
    assert property (!line_rate && !$past(line_rate) |-> transfer_pulse_a == transfer_pulse_b)
    else $error("transfer outputs differ");
  a_line_end_quiet:
    assert property (run && pix_end && !fake_black && !line_rate |=> !reset_sample_pulse && !aux_pixel_pulse_a)
    else $error("sample pulse at line end");
  a_scan_on_line:
    assert property (scan_start |-> line_start && (illum_mode != SSLT_ILLUM_COLOR || line_colour == SSLT_RED))
    else $error("scan started off a line boundary");
  a_colour_wrap_red:
    assert property (wrap && col == SSLT_BLUE |=> col == SSLT_RED)
    else $error("colour counter did not wrap");
  a_convert_every8:
    assert property (run && conv ##1 run [*8] |-> conv)
    else $error("conversion spacing not eight clocks");
  a_guard_zero_align:
    assert property (run && tr_guard == `SSLT_CNT_ZERO && tr_mode == SSLT_TR_NORMAL && !line_rate && $rose(transfer_pulse_a)
                     |-> phi1)
    else $error("zero guardband transfer without phase one");

  c_scan_start: cover property (scan_start);
  c_blue_transfer: cover property (line_rate && aux_pixel_pulse_b);
  c_fake_black: cover property (fake_black && reset_sample_pulse && transfer_pulse_a);

endmodule
